// ### ars_axis_search.sv
`timescale 1ns/1ps
// How it works
// - A state machine runs the search and is started, stopped and polled by a command word carrying opcode 13.
// - The end-switch automatic stop settings are forced inactive while a search runs.
// - The axis moves at the search speed until the reference switch is first seen.
// - After a hit modes 1, 2, 5 and 6 creep back at calibration speed until release and re-enter; modes 3, 4, 7, 8 creep through; zero is the midpoint.
// - The mode register selects one of eight search procedures numbered 1 to 8.
// - Mode 1 searches the left end switch, or the right one when 64 is added.
// - Mode 2 searches right then left, zeroes on left, and reports the switch distance.
// - Mode 2 with the swap bit searches left first and zeroes on the right switch.
// - Mode 3 searches right, then takes the middle of the left switch as zero and reports the distance.
// - Mode 3 with the swap bit searches left first and zeroes on the middle of the right switch.
// - Mode 4 finds the middle of the left switch, or of the right one with the swap bit.
// - Mode 5 seeks home in negative direction and reverses at the left limit.
// - Mode 6 seeks home in positive direction and reverses at a limit switch.
// - Mode 7 seeks home positively, ignores the limits and zeroes on the home switch middle.
// - Mode 8 seeks home negatively and ignores the limits.
// - Adding 128 inverts the home switch polarity in modes 5 to 8.
module ars_axis_search import ars_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic sw_left_i,
	input wire logic sw_right_i,
	input wire logic sw_home_i,
	output logic step_o,
	output logic dir_o,
	output logic busy_o,
	output logic limit_stop_o
);
	ars_state_t state_q;
	logic ack_q, req, wr, cmd_wr, start_cmd, stop_cmd, err_q, abort_q, step, run, swap;
	logic [31:0] dat_q, rd_d, pos_q, dist_q, first_q, e1_q, ctr_q;
	logic [5:0] idx, base;
	logic [7:0] mode_q;
	logic [15:0] search_period_q, cal_period_q, period;
	logic [1:0] autostop_q;
	logic [2:0] sw_lvl;
	logic dec_valid, dec_has_first, dec_dir_first, dec_dir_seek, dec_thru, dec_rev;
	ars_sel_t dec_sel_first, dec_sel_seek, sel_first_q, sel_seek_q;
	logic has_first_q, dir_seek_q, thru_q, rev_q, inv_q, dir_q, cal_q;
	logic first_hit, seek_hit, limit_ahead;

	////////////////////////////////////////////////////////////////////////////
	// Switch inputs and step generation

	ars_sync u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.raw_i({sw_home_i, sw_right_i, sw_left_i}),
		.lvl_o(sw_lvl)
	);

	// Speed is a step period of the value plus one clock cycles, so a larger value moves slower
	assign run = (state_q == ST_FIRST) || (state_q == ST_SEEK) || (state_q == ST_THRU) ||
		(state_q == ST_OUT) || (state_q == ST_IN);
	assign period = cal_q ? cal_period_q : search_period_q;

	ars_stepgen u_step (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.run_i(run),
		.period_i(period),
		.step_o(step)
	);

	assign step_o = step;
	assign dir_o = dir_q;
	assign busy_o = (state_q != ST_IDLE);

	////////////////////////////////////////////////////////////////////////////
	// Wishbone slave

	// Ack one cycle after a request and take no request in the ack cycle, so a strobe still high with the ack is not taken twice
	assign req = wb_cyc_i && wb_stb_i && !ack_q;
	assign wr = req && wb_we_i;
	assign idx = wb_adr_i[7:2];
	assign cmd_wr = wr && (idx == IDX_CMD) && (&wb_sel_i[1:0]) &&
		(wb_dat_i[CMD_OP_LSB +: 8] == ARS_OPCODE);
	assign start_cmd = cmd_wr && (wb_dat_i[CMD_TYPE_LSB +: 2] == CMD_START);
	assign stop_cmd = cmd_wr && (wb_dat_i[CMD_TYPE_LSB +: 2] == CMD_STOP);

	// Read mux; unmapped words read as zero
	always_comb begin
		rd_d = 32'h0000_0000;
		case (idx)
			IDX_CMD: begin
				rd_d[STAT_BUSY_BIT] = busy_o;
				rd_d[STAT_ERR_BIT] = err_q;
				rd_d[STAT_ABORT_BIT] = abort_q;
			end
			IDX_MODE: rd_d[7:0] = mode_q;
			IDX_SEARCH: rd_d[15:0] = search_period_q;
			IDX_CAL: rd_d[15:0] = cal_period_q;
			IDX_DIST: rd_d = dist_q;
			IDX_POS: rd_d = pos_q;
			IDX_AUTOSTOP: rd_d[1:0] = autostop_q;
			default: rd_d = 32'h0000_0000;
		endcase
	end

	// Answer one cycle after the request
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
			dat_q <= 32'h0000_0000;
		end else begin
			ack_q <= req;
			if (req && !wb_we_i) begin
				dat_q <= rd_d;
			end
		end
	end

	assign wb_ack_o = ack_q;
	assign wb_dat_o = dat_q;

	// Configuration writes; mode changes take effect at the next start, speed and autostop changes at once
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			mode_q <= MODE_RST;
			search_period_q <= SEARCH_PERIOD_RST;
			cal_period_q <= CAL_PERIOD_RST;
			autostop_q <= AUTOSTOP_RST;
		end else if (wr) begin
			case (idx)
				IDX_MODE: mode_q <= 8'(ars_merge({24'h0, mode_q}, wb_dat_i, wb_sel_i));
				IDX_SEARCH: search_period_q <= 16'(ars_merge({16'h0, search_period_q}, wb_dat_i, wb_sel_i));
				IDX_CAL: cal_period_q <= 16'(ars_merge({16'h0, cal_period_q}, wb_dat_i, wb_sel_i));
				IDX_AUTOSTOP: autostop_q <= 2'(ars_merge({30'h0, autostop_q}, wb_dat_i, wb_sel_i));
				default: ;
			endcase
		end
	end

	// End-switch stop is suppressed from the start edge on, since busy_o rises at that edge and is only seen here one edge later
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			limit_stop_o <= 1'b0;
		end else begin
			limit_stop_o <= !busy_o && !start_cmd &&
				((autostop_q[0] && sw_lvl[0]) || (autostop_q[1] && sw_lvl[1]));
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Mode decode

	assign base = mode_q[5:0];
	assign swap = mode_q[MODE_SWAP_BIT];

	// Turn the mode value into a plan of switches and directions; dir 1 is positive
	always_comb begin
		dec_valid = 1'b1;
		dec_has_first = 1'b0;
		dec_sel_first = SEL_RIGHT;
		dec_dir_first = 1'b1;
		dec_sel_seek = SEL_LEFT;
		dec_dir_seek = 1'b0;
		dec_thru = 1'b0;
		dec_rev = 1'b0;
		case (base)
			MODE_LEFT_ONLY, MODE_LEFT_MID: begin
				dec_sel_seek = swap ? SEL_RIGHT : SEL_LEFT;
				dec_dir_seek = swap;
				dec_thru = (base == MODE_LEFT_MID);
			end
			MODE_RIGHT_LEFT, MODE_RIGHT_LEFT_MID: begin
				dec_has_first = 1'b1;
				dec_sel_first = swap ? SEL_LEFT : SEL_RIGHT;
				dec_dir_first = !swap;
				dec_sel_seek = swap ? SEL_RIGHT : SEL_LEFT;
				dec_dir_seek = swap;
				dec_thru = (base == MODE_RIGHT_LEFT_MID);
			end
			MODE_HOME_NEG_REV: begin
				dec_sel_seek = SEL_HOME;
				dec_rev = 1'b1;
			end
			MODE_HOME_POS_REV: begin
				dec_sel_seek = SEL_HOME;
				dec_dir_seek = 1'b1;
				dec_rev = 1'b1;
			end
			MODE_HOME_POS_FREE: begin
				dec_sel_seek = SEL_HOME;
				dec_dir_seek = 1'b1;
				dec_thru = 1'b1;
			end
			MODE_HOME_NEG_FREE: begin
				dec_sel_seek = SEL_HOME;
				dec_thru = 1'b1;
			end
			default: dec_valid = 1'b0;
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// Search state machine

	assign first_hit = ars_active(sel_first_q, sw_lvl, 1'b0);
	assign seek_hit = ars_active(sel_seek_q, sw_lvl, inv_q);
	// Only the limit in the direction of travel reverses, so a held switch cannot flip twice
	assign limit_ahead = dir_q ? sw_lvl[1] : sw_lvl[0];

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_q <= ST_IDLE;
			has_first_q <= 1'b0;
			sel_first_q <= SEL_RIGHT;
			sel_seek_q <= SEL_LEFT;
			dir_seek_q <= 1'b0;
			thru_q <= 1'b0;
			rev_q <= 1'b0;
			inv_q <= 1'b0;
			dir_q <= 1'b0;
			cal_q <= 1'b0;
			first_q <= 32'h0000_0000;
			e1_q <= 32'h0000_0000;
			ctr_q <= 32'h0000_0000;
			err_q <= 1'b0;
			abort_q <= 1'b0;
		end else if (stop_cmd && state_q != ST_IDLE) begin
			state_q <= ST_IDLE;
			abort_q <= 1'b1;
			cal_q <= 1'b0;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (start_cmd && !dec_valid) begin
						err_q <= 1'b1;
					end else if (start_cmd) begin
						err_q <= 1'b0;
						abort_q <= 1'b0;
						has_first_q <= dec_has_first;
						sel_first_q <= dec_sel_first;
						sel_seek_q <= dec_sel_seek;
						dir_seek_q <= dec_dir_seek;
						thru_q <= dec_thru;
						rev_q <= dec_rev;
						inv_q <= mode_q[MODE_INV_BIT] && (dec_sel_seek == SEL_HOME);
						dir_q <= dec_has_first ? dec_dir_first : dec_dir_seek;
						cal_q <= 1'b0;
						state_q <= dec_has_first ? ST_FIRST : ST_SEEK;
					end
				end
				ST_FIRST: begin
					if (first_hit) begin
						first_q <= pos_q;
						dir_q <= dir_seek_q;
						state_q <= ST_SEEK;
					end
				end
				ST_SEEK: begin
					if (seek_hit) begin
						e1_q <= pos_q;
						cal_q <= 1'b1;
						if (thru_q) begin
							state_q <= ST_THRU;
						end else begin
							dir_q <= !dir_q;
							state_q <= ST_OUT;
						end
					end else if (rev_q && limit_ahead) begin
						dir_q <= !dir_q;
					end
				end
				ST_THRU: begin
					// Passing through the switch gives its two edges in one sweep
					if (!seek_hit) begin
						ctr_q <= ars_center(e1_q, pos_q);
						state_q <= ST_DONE;
					end
				end
				ST_OUT: begin
					if (!seek_hit) begin
						e1_q <= pos_q;
						dir_q <= !dir_q;
						state_q <= ST_IN;
					end
				end
				ST_IN: begin
					if (seek_hit) begin
						ctr_q <= ars_center(e1_q, pos_q);
						state_q <= ST_DONE;
					end
				end
				ST_DONE: begin
					cal_q <= 1'b0;
					state_q <= ST_IDLE;
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// Position counter; a step issued on the last moving cycle is still counted
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pos_q <= 32'h0000_0000;
		end else begin
			pos_q <= pos_q + (step ? (dir_q ? 32'h0000_0001 : 32'hffff_ffff) : 32'h0000_0000) -
				((state_q == ST_DONE) ? ctr_q : 32'h0000_0000);
		end
	end

	// Switch distance is reported only by procedures that visit two switches
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dist_q <= 32'h0000_0000;
		end else if (state_q == ST_DONE) begin
			dist_q <= has_first_q ? ars_absdiff(first_q, ctr_q) : 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	sequence s_start_ok;
		state_q == ST_IDLE && start_cmd && dec_valid;
	endsequence

	sequence s_out_release;
		state_q == ST_OUT && !seek_hit && !stop_cmd;
	endsequence

	a_start_busy: assert property (s_start_ok |=> busy_o ##1 busy_o)
		else $error("start did not make the search busy");
	a_stop_idle: assert property (stop_cmd |=> state_q == ST_IDLE && !busy_o && !run)
		else $error("stop did not end the search");
	a_autostop_off: assert property ((busy_o || start_cmd) |=> !limit_stop_o)
		else $error("end-switch stop active during search");
	a_search_speed: assert property ((state_q == ST_FIRST || state_q == ST_SEEK) |-> period == search_period_q)
		else $error("wrong speed before first hit");
	a_cal_speed: assert property ((state_q == ST_OUT || state_q == ST_IN || state_q == ST_THRU) |->
		period == cal_period_q)
		else $error("wrong calibration speed");
	a_cal_turn: assert property (s_out_release |=> state_q == ST_IN && dir_q != $past(dir_q))
		else $error("no turn after switch release");
	a_zero_center: assert property (state_q == ST_DONE && !step |=> pos_q == $past(pos_q) - $past(ctr_q))
		else $error("zero not placed at midpoint");
	a_mode_reject: assert property (state_q == ST_IDLE && start_cmd && !dec_valid |=> state_q == ST_IDLE && err_q)
		else $error("invalid mode started");
	a_mode2_order: assert property (s_start_ok and (base == MODE_RIGHT_LEFT) |=>
		sel_first_q == (swap ? SEL_LEFT : SEL_RIGHT) && dir_q == !swap)
		else $error("mode 2 first switch wrong");
	a_limit_reverse: assert property (state_q == ST_SEEK && rev_q && !seek_hit && limit_ahead && !stop_cmd |=>
		dir_q != $past(dir_q))
		else $error("no reversal at limit");
	a_limits_ignored: assert property (state_q == ST_SEEK && sel_seek_q == SEL_HOME && !rev_q && !seek_hit && !stop_cmd
		|=> state_q == ST_SEEK && dir_q == $past(dir_q))
		else $error("limit affected free home search");
	a_home_polarity: assert property (state_q == ST_SEEK && sel_seek_q == SEL_HOME && (sw_lvl[2] ^ inv_q) && !stop_cmd
		|=> state_q != ST_SEEK)
		else $error("home level not taken with selected polarity");
	a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held longer than one cycle");
endmodule // ars_axis_search

// ### ars_axis_search_tb.sv
`timescale 1ns/1ps
module ars_axis_search_tb import ars_pkg::*;;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic wb_cyc = 1'b0;
	logic wb_stb = 1'b0;
	logic wb_we = 1'b0;
	logic [7:0] wb_adr = 8'h00;
	logic [3:0] wb_sel = 4'h0;
	logic [31:0] wb_dat = 32'h0;
	logic home_low = 1'b0;
	logic [31:0] wb_dat_o;
	logic wb_ack_o, sw_left, sw_right, sw_home, step_o, dir_o, busy_o, limit_stop_o;
	logic [32:0] notes[$];
	logic [32:0] note;
	int n_errors = 0;
	int total_checks = 0;
	int steps = 0;
	////////////////////////////////////////////////////////////////////////////////
	// Clock of 100 ns, design and stage
	always #50 clk_i = ~clk_i;
	ars_axis_search i_ars_axis_search (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
		.wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .sw_left_i(sw_left), .sw_right_i(sw_right), .sw_home_i(sw_home),
		.step_o(step_o), .dir_o(dir_o), .busy_o(busy_o), .limit_stop_o(limit_stop_o));
	ars_stage_model i_ars_stage_model (.clk_i(clk_i), .rst_i(rst_i), .step_i(step_o), .dir_i(dir_o),
		.home_low_i(home_low), .sw_left_o(sw_left), .sw_right_o(sw_right), .sw_home_o(sw_home));
	////////////////////////////////////////////////////////////////////////////////
	task automatic results();
		if (n_errors == 0 && total_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	task automatic check32(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check1(input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			n_errors++;
			$display("FAIL %0t flag %b expected %b", $time, got, exp);
		end
	endtask
	task automatic hang();
		n_errors++;
		$display("FAIL %0t wait timed out", $time);
		results();
	endtask
	// One classic cycle; the note tells the watcher what read data to expect
	task automatic wb(input logic we, input logic [5:0] idx, input logic [31:0] dat, input logic chk);
		int i;
		notes.push_back({chk, dat});
		wb_cyc <= 1'b1;
		wb_stb <= 1'b1;
		wb_we <= we;
		wb_adr <= {idx, 2'b00};
		wb_sel <= 4'hf;
		wb_dat <= we ? dat : $urandom();
		i = 0;
		do begin
			@(posedge clk_i);
			i++;
			if (i > 50) hang();
		end while (wb_ack_o !== 1'b1);
		wb_cyc <= 1'b0;
		wb_stb <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [5:0] idx, input logic [31:0] dat);
		wb(1'b1, idx, dat, 1'b0);
	endtask
	task automatic rd(input logic [5:0] idx, input logic [31:0] exp);
		wb(1'b0, idx, exp, 1'b1);
	endtask
	// Upper command bits are random; only opcode and type carry meaning
	task automatic cmd(input logic [1:0] t);
		logic [31:0] r;
		r = $urandom();
		r[9:0] = {t, ARS_OPCODE};
		wr(IDX_CMD, r);
	endtask
	task automatic wait_idle();
		int i;
		i = 0;
		while (busy_o !== 1'b0) begin
			@(posedge clk_i);
			i++;
			if (i > 20000) hang();
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// Watcher pairs each ack with the oldest note; also counts steps and polices end-switch stops
	always @(posedge clk_i) begin
		if (wb_ack_o === 1'b1 && notes.size() > 0) begin
			note = notes.pop_front();
			if (note[32]) begin
				check32(wb_dat_o, note[31:0]);
			end
		end
		if (step_o === 1'b1) begin
			steps++;
		end
		if (busy_o === 1'b1) begin
			check1(limit_stop_o, 1'b0);
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Expected zero offsets follow from cam edges: midpoint of the two switching points, floored
	initial begin
		logic [7:0] md[14] = '{8'h01, 8'h41, 8'h02, 8'h42, 8'h03, 8'h43, 8'h04, 8'h44, 8'h05, 8'h06, 8'h07,
			8'h08, 8'h85, 8'h88};
		int ep[14] = '{0, 1, 0, 1, -5, 6, -5, 6, 0, 0, 6, -5, 0, -5};
		int ed[14] = '{0, 0, 100, 99, 106, 105, 0, 0, 0, 0, 0, 0, 0, 0};
		logic [7:0] bad[2] = '{8'h00, 8'h09};
		void'($urandom(7347));
		repeat (16) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		rd(IDX_MODE, {24'h0, MODE_RST});
		rd(IDX_SEARCH, {16'h0, SEARCH_PERIOD_RST});
		rd(IDX_CAL, {16'h0, CAL_PERIOD_RST});
		rd(IDX_AUTOSTOP, 32'h0);
		rd(IDX_DIST, 32'h0);
		rd(IDX_CMD, 32'h0);
		wr(IDX_POS, $urandom());
		rd(IDX_POS, 32'h0);
		wr(6'h10, $urandom());
		rd(6'h10, 32'h0);
		// Procedures outside 1 to 8 refuse to start and flag the error
		foreach (bad[j]) begin
			wr(IDX_MODE, {24'h0, bad[j]});
			cmd(CMD_START);
			rd(IDX_CMD, 32'h2);
		end
		// Every procedure and swap variant, inverted polarity for modes 5 and 8, each from a fresh reset at stage position zero
		for (int k = 0; k < 14; k++) begin
			rst_i <= 1'b1;
			home_low <= md[k][7];
			repeat (2) @(posedge clk_i);
			rst_i <= 1'b0;
			@(posedge clk_i);
			wr(IDX_SEARCH, 32'h9);
			wr(IDX_CAL, 32'hb);
			wr(IDX_AUTOSTOP, 32'h3);
			wr(IDX_MODE, {24'h0, md[k]});
			rd(IDX_MODE, {24'h0, md[k]});
			cmd(CMD_START);
			rd(IDX_CMD, 32'h1);
			wait_idle();
			rd(IDX_POS, ep[k]);
			rd(IDX_DIST, ed[k]);
			check1(limit_stop_o, sw_left | sw_right);
		end
		// Inverted mode 8 from the last home runs into the left cam: search rate, then a stop mid-run
		wr(IDX_MODE, 32'h88);
		cmd(CMD_START);
		repeat (20) @(posedge clk_i);
		steps = 0;
		repeat (200) @(posedge clk_i);
		check32(steps, 32'd20);
		cmd(CMD_STOP);
		cmd(CMD_STATUS);
		rd(IDX_CMD, 32'h4);
		steps = 0;
		repeat (50) @(posedge clk_i);
		check32(steps, 32'd0);
		check1(busy_o, 1'b0);
		// Mode 5 stopped inside the left cam turns at once and centres home from below
		wr(IDX_MODE, 32'h85);
		cmd(CMD_START);
		wait_idle();
		rd(IDX_POS, 32'h1);
		results();
	end
endmodule // ars_axis_search_tb

// ### ars_pkg.sv
package ars_pkg;

	// Command word accepted by the reference search command register
	localparam logic [7:0] ARS_OPCODE = 8'h0d;
	localparam int CMD_OP_LSB = 0;
	localparam int CMD_TYPE_LSB = 8;
	localparam logic [1:0] CMD_START = 2'h0;
	localparam logic [1:0] CMD_STOP = 2'h1;
	localparam logic [1:0] CMD_STATUS = 2'h2;

	// Register word indices, byte address is index times four
	localparam logic [5:0] IDX_CMD = 6'h00;
	localparam logic [5:0] IDX_MODE = 6'h01;
	localparam logic [5:0] IDX_SEARCH = 6'h02;
	localparam logic [5:0] IDX_CAL = 6'h03;
	localparam logic [5:0] IDX_DIST = 6'h04;
	localparam logic [5:0] IDX_POS = 6'h05;
	localparam logic [5:0] IDX_AUTOSTOP = 6'h06;

	// Status bits in the command register read value
	localparam int STAT_BUSY_BIT = 0;
	localparam int STAT_ERR_BIT = 1;
	localparam int STAT_ABORT_BIT = 2;

	// Mode register layout and values
	localparam int MODE_SWAP_BIT = 6;
	localparam int MODE_INV_BIT = 7;
	localparam logic [5:0] MODE_LEFT_ONLY = 6'h01;
	localparam logic [5:0] MODE_RIGHT_LEFT = 6'h02;
	localparam logic [5:0] MODE_RIGHT_LEFT_MID = 6'h03;
	localparam logic [5:0] MODE_LEFT_MID = 6'h04;
	localparam logic [5:0] MODE_HOME_NEG_REV = 6'h05;
	localparam logic [5:0] MODE_HOME_POS_REV = 6'h06;
	localparam logic [5:0] MODE_HOME_POS_FREE = 6'h07;
	localparam logic [5:0] MODE_HOME_NEG_FREE = 6'h08;

	// Reset values
	localparam logic [7:0] MODE_RST = 8'h01;
	localparam logic [15:0] SEARCH_PERIOD_RST = 16'h0064;
	localparam logic [15:0] CAL_PERIOD_RST = 16'h03e8;
	localparam logic [1:0] AUTOSTOP_RST = 2'h0;

	typedef enum logic [1:0] {SEL_LEFT = 2'h0, SEL_RIGHT = 2'h1, SEL_HOME = 2'h2} ars_sel_t;

	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_FIRST = 7'h02,
		ST_SEEK = 7'h04,
		ST_THRU = 7'h08,
		ST_OUT = 7'h10,
		ST_IN = 7'h20,
		ST_DONE = 7'h40
	} ars_state_t;

	// Byte-lane merge of a bus write into a stored word
	function automatic logic [31:0] ars_merge(input logic [31:0] old_v, input logic [31:0] new_v,
			input logic [3:0] sel);
		logic [31:0] r;
		r = old_v;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[8*b +: 8] = new_v[8*b +: 8];
			end
		end
		return r;
	endfunction

	// Midpoint of two switching positions
	function automatic logic [31:0] ars_center(input logic [31:0] a, input logic [31:0] b);
		logic [32:0] s;
		s = {a[31], a} + {b[31], b};
		return s[32:1];
	endfunction

	// Unsigned distance between two positions
	function automatic logic [31:0] ars_absdiff(input logic [31:0] a, input logic [31:0] b);
		logic [31:0] d;
		d = a - b;
		return d[31] ? (32'h0 - d) : d;
	endfunction

	// Active level of a selected switch, home polarity optionally inverted
	function automatic logic ars_active(input ars_sel_t sel, input logic [2:0] lvl, input logic inv);
		logic r;
		r = 1'b0;
		case (sel)
			SEL_LEFT: r = lvl[0];
			SEL_RIGHT: r = lvl[1];
			SEL_HOME: r = lvl[2] ^ inv;
			default: r = 1'b0;
		endcase
		return r;
	endfunction

endpackage

// ### ars_stage_model.sv
`timescale 1ns/1ps
// Stage with three cam switches; position wraps every SPAN steps so a free home search comes round
module ars_stage_model #(
	parameter int SPAN = 200
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic step_i,
	input wire logic dir_i,
	input wire logic home_low_i,
	output logic sw_left_o,
	output logic sw_right_o,
	output logic sw_home_o
);
	int pos_q;
	int w;
	////////////////////////////////////////////////////////////////////////////////
	// One microstep per step pulse, dir high counts up
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			pos_q <= 0;
		end else if (step_i) begin
			pos_q <= dir_i ? pos_q + 1 : pos_q - 1;
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	// Cams are eleven steps wide so pass-through searches see both edges
	always_comb begin
		w = pos_q % SPAN;
		if (w >= SPAN / 2) begin
			w = w - SPAN;
		end
		if (w < -SPAN / 2) begin
			w = w + SPAN;
		end
		sw_left_o = (w >= -60) && (w <= -50);
		sw_right_o = (w >= 50) && (w <= 60);
		sw_home_o = ((w >= -30) && (w <= -20)) ^ home_low_i; // Pin level flips for active-low homes
	end
endmodule // ars_stage_model

// ### ars_stepgen.sv
`timescale 1ns/1ps
// Step pulse generator: one pulse every period plus one cycles while running
module ars_stepgen import ars_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic run_i,
	input wire logic [15:0] period_i,
	output logic step_o
);
	logic [15:0] cnt_q;
	logic step_q;

	// Counter restarts whenever motion stops, so a new move begins with a full period
	always_ff @(posedge clk_i) begin
		if (rst_i || !run_i) begin
			cnt_q <= 16'h0000;
			step_q <= 1'b0;
		end else if (cnt_q >= period_i) begin
			cnt_q <= 16'h0000;
			step_q <= 1'b1;
		end else begin
			cnt_q <= cnt_q + 16'h0001;
			step_q <= 1'b0;
		end
	end

	assign step_o = step_q;
endmodule // ars_stepgen

// ### ars_sync.sv
`timescale 1ns/1ps
// Three-stage switch synchroniser; a level counts once stages two and three agree
module ars_sync import ars_pkg::*; (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [2:0] raw_i,
	output logic [2:0] lvl_o
);
	logic [2:0] s1_q;
	logic [2:0] s2_q;
	logic [2:0] s3_q;
	logic [2:0] lvl_q;

	// Stage one feeds only stage two, so metastability never reaches the filter
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_q <= 3'h0;
			s2_q <= 3'h0;
			s3_q <= 3'h0;
		end else begin
			s1_q <= raw_i;
			s2_q <= s1_q;
			s3_q <= s2_q;
		end
	end

	// Hold the old level while the late stages disagree
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lvl_q <= 3'h0;
		end else begin
			lvl_q <= (~(s2_q ^ s3_q) & s3_q) | ((s2_q ^ s3_q) & lvl_q);
		end
	end

	assign lvl_o = lvl_q;
endmodule // ars_sync
